//--- pdw_pkg.sv
package pdw_pkg;
	// Window geometry
	localparam int unsigned WIN_BYTES       = 32768;        // One page equals the 32 Kbyte window
	localparam int unsigned DADDR_W         = 16;           // Core data address width
	localparam int unsigned PAGE_W          = 9;            // Page register width, bit 8 picks program space
	localparam int unsigned EFF_ADDR_W      = 24;           // Effective address width
	localparam int unsigned WIN_BIT         = 15;           // Top data address bit marks a window access
	localparam int unsigned PROG_VIEW_BIT   = 8;            // Read page bit that selects program space
	// Base data memory range; page zero window accesses trap
	localparam logic [15:0] BASE_LO         = 16'h0800;
	localparam logic [15:0] BASE_HI         = 16'h7FFF;
	// Memory sizes
	localparam logic [23:0] INT_RAM_BYTES   = 24'h002000;   // 8K internal RAM
	localparam logic [23:0] EXT_LARGE_BYTES = 24'hFFFFFF;   // Up to 16 Mbytes, last byte address
	localparam logic [23:0] EXT_SMALL_BYTES = 24'h00FFFF;   // Up to 64K, last byte address
	localparam logic [8:0]  PAGE_RESET      = 9'h001;       // Page registers start on page one
	// Access target
	typedef enum logic [2:0] {PDW_TGT_NONE, PDW_TGT_BASE, PDW_TGT_INT, PDW_TGT_EXT, PDW_TGT_PROG} pdw_tgt_e;
endpackage : pdw_pkg

//--- pdw_page_reg.sv
`timescale 1ns/100ps
`default_nettype none
// Holds one page select; loaded by the core when it writes the page
module pdw_page_reg (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Load port
	input  wire logic       load,
	input  wire logic [8:0] load_value,
	// Current page
	output logic      [8:0] page
);
	logic [8:0] next_page;  // Value for the next edge

	// Next value: load wins, otherwise hold
	always_comb
	begin
		next_page = load ? load_value : page;
	end

	// Register stage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			page <= pdw_pkg::PAGE_RESET;
		else
			page <= next_page;
	end
endmodule : pdw_page_reg
`default_nettype wire

//--- pdw_window.sv
`timescale 1ns/100ps
`default_nettype none
module pdw_window (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Variant strap: high for the larger parallel port
	input  wire logic        large_port,
	// Page select loads from the core
	input  wire logic        read_page_load,
	input  wire logic        write_page_load,
	input  wire logic [8:0]  page_value,
	// Core data access
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [15:0] daddr,
	// Translated access
	output logic             acc_valid,
	output logic             acc_we,
	output pdw_pkg::pdw_tgt_e acc_tgt,
	output logic      [23:0] effective_address,
	output logic             address_error_trap,
	// Current pages
	output logic      [8:0]  read_page_select,
	output logic      [8:0]  write_page_select
);
	logic              rst_meta;        // First reset synchroniser stage
	logic              rst_sync_n;      // Released reset used everywhere
	logic              large_meta;      // Strap pin, first flop; may go metastable
	logic              large_q;         // Strap pin, second flop; the only copy logic reads
	logic              next_large_meta; // Strap pin as seen this cycle
	logic              next_large_q;    // First strap flop moving on
	logic              next_valid;      // Access taken this cycle
	logic              next_we;         // Direction of the access
	pdw_pkg::pdw_tgt_e next_tgt;        // Where the access lands
	logic [23:0]       next_eff_addr;   // Translated address
	logic              next_trap;       // Access refused
	logic [8:0]        page;            // Page chosen for this access
	logic              window;          // Access falls in the upper half

	// Combine page and 15-bit window offset into an address
	function automatic logic [23:0] form_eff_addr(input logic [8:0] pg, input logic [15:0] a);
		form_eff_addr = {pg, a[14:0]};
	endfunction : form_eff_addr

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Page registers
	pdw_page_reg u_read_page (
		.clk_sys    (clk_sys),
		.rst_n      (rst_sync_n),
		.load       (read_page_load),
		.load_value (page_value),
		.page       (read_page_select)
	);
	pdw_page_reg u_write_page (
		.clk_sys    (clk_sys),
		.rst_n      (rst_sync_n),
		.load       (write_page_load),
		.load_value (page_value),
		.page       (write_page_select)
	);

	// Translation: pick the page, form the address and decide the target
	always_comb
	begin
		window          = daddr[pdw_pkg::WIN_BIT];
		page            = we ? write_page_select : read_page_select;
		next_large_meta = large_port;
		next_large_q    = large_meta;
		next_valid      = req;
		next_we         = we;
		next_trap       = 1'b0;
		next_tgt        = pdw_pkg::PDW_TGT_NONE;
		next_eff_addr   = {8'h00, daddr};                                   // Base accesses pass unpaged
		if (req)
		begin
			if (!window)
				next_tgt = pdw_pkg::PDW_TGT_BASE;
			else if (page == 9'h000)
				next_trap = 1'b1;
			else
			begin
				next_eff_addr = form_eff_addr(page, daddr);
				if (page[pdw_pkg::PROG_VIEW_BIT])
				begin
					// Program space: reads only, write gets a trap
					if (we)
						next_trap = 1'b1;
					else
						next_tgt = pdw_pkg::PDW_TGT_PROG;
				end
				// Internal RAM target; a window page is never zero, so with 8K fitted
				// this branch stays idle until a part carries more internal memory
				else if (next_eff_addr < pdw_pkg::INT_RAM_BYTES)
					next_tgt = pdw_pkg::PDW_TGT_INT;
				else if (large_q || next_eff_addr <= pdw_pkg::EXT_SMALL_BYTES)
					next_tgt = pdw_pkg::PDW_TGT_EXT;
				else
					next_trap = 1'b1;                                       // Beyond small port reach
			end
		end
	end

	// Output registers; the strap also passes its two flops here, as it is a pin
	// from outside the clock domain and may change at any time
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			large_meta         <= 1'b0;
			large_q            <= 1'b0;
			acc_valid          <= 1'b0;
			acc_we             <= 1'b0;
			acc_tgt            <= pdw_pkg::PDW_TGT_NONE;
			effective_address  <= 24'h000000;
			address_error_trap <= 1'b0;
		end
		else
		begin
			large_meta         <= next_large_meta;
			large_q            <= next_large_q;
			acc_valid          <= next_valid;
			acc_we             <= next_we;
			acc_tgt            <= next_tgt;
			effective_address  <= next_eff_addr;
			address_error_trap <= next_trap;
		end
	end

	// Named steps of a core access, shared by the checks below
	sequence win_read_s;
		req && daddr[pdw_pkg::WIN_BIT] && !we;
	endsequence : win_read_s
	sequence win_write_s;
		req && daddr[pdw_pkg::WIN_BIT] && we;
	endsequence : win_write_s
	sequence base_acc_s;
		req && !daddr[pdw_pkg::WIN_BIT];
	endsequence : base_acc_s

	// Page zero window access traps next cycle
	page_zero_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		req && daddr[15] && ((we ? write_page_select : read_page_select) == 9'h000) |=> address_error_trap)
		else $error("page zero not trapped");

	// Window read address carries the read page
	addr_form_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		win_read_s ##0 read_page_select != 9'h000
		|=> effective_address == {$past(read_page_select), $past(daddr[14:0])})
		else $error("bad address");

	// Writes use the write page
	write_page_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		win_write_s ##0 write_page_select != 9'h000 && !write_page_select[pdw_pkg::PROG_VIEW_BIT]
		|=> effective_address[23:15] == $past(write_page_select))
		else $error("wrong write page");

	// Program space never written
	prog_ro_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		acc_valid && acc_tgt == pdw_pkg::PDW_TGT_PROG |-> !acc_we)
		else $error("program write");

	// Low half is unpaged
	base_pass_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		base_acc_s |=> acc_tgt == pdw_pkg::PDW_TGT_BASE && !address_error_trap)
		else $error("base paged");

	// Small port limit
	small_port_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		acc_tgt == pdw_pkg::PDW_TGT_EXT && !$past(large_q) |-> effective_address <= pdw_pkg::EXT_SMALL_BYTES)
		else $error("ext too far");

	// Internal RAM within 8K
	int_ram_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		acc_tgt == pdw_pkg::PDW_TGT_INT |-> effective_address < pdw_pkg::INT_RAM_BYTES)
		else $error("int ram range");

	// Page spans 32 Kbytes of offset
	page_span_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		req && daddr[pdw_pkg::WIN_BIT] |=> effective_address[14:0] == $past(daddr[14:0]))
		else $error("span");

	// Every taken access is answered exactly one cycle later
	valid_follow_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		req |=> acc_valid)
		else $error("access not answered");

	// No answer without a request the cycle before
	valid_idle_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		!req |=> !acc_valid)
		else $error("answer without request");

	// A refused access names no target
	trap_no_target_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		address_error_trap |-> acc_tgt == pdw_pkg::PDW_TGT_NONE)
		else $error("trap with target");

	// Program-space reads take their page from the read page only
	prog_read_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		win_read_s ##0 read_page_select[pdw_pkg::PROG_VIEW_BIT]
		|=> acc_tgt == pdw_pkg::PDW_TGT_PROG && effective_address[23:15] == $past(read_page_select))
		else $error("program read misrouted");

	// Program space cannot be written through the window
	prog_write_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		win_write_s ##0 write_page_select[pdw_pkg::PROG_VIEW_BIT] |=> address_error_trap)
		else $error("program write not refused");

	// Base accesses keep their own address
	base_addr_a : assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		base_acc_s |=> effective_address == {8'h00, $past(daddr)})
		else $error("base address altered");
endmodule : pdw_window
`default_nettype wire

//--- pdw_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Core side of the window: loads pages and issues data accesses on falling edges
module pdw_core_model (
	// Clock
	input  wire logic        clk_sys,
	// Page loads
	output logic             read_page_load,
	output logic             write_page_load,
	output logic [8:0]       page_value,
	// Data access
	output logic             req,
	output logic             we,
	output logic [15:0]      daddr
);
	// Quiet core at time zero
	initial
	begin
		{read_page_load, write_page_load, req, we} = 4'h0;
		page_value = 9'h000;
		daddr = 16'h0000;
	end
	// Load read page, then write page; address lines are scrambled while idle so no stale value helps
	task automatic load(input logic [8:0] r, input logic [8:0] w);
		req = 1'b0;
		daddr = ~daddr;
		read_page_load = 1'b1;
		page_value = r;
		@(negedge clk_sys);
		read_page_load = 1'b0;
		write_page_load = 1'b1;
		page_value = w;
		@(negedge clk_sys);
		write_page_load = 1'b0;
		page_value = ~w;
	endtask : load
	// One access; request stays up so accesses can run back to back
	task automatic issue(input logic w, input logic [15:0] a);
		req = 1'b1;
		we = w;
		daddr = a;
		@(negedge clk_sys);
	endtask : issue
endmodule : pdw_core_model
`default_nettype wire

//--- paged_data_window_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module paged_data_window_bench;
	logic              clk_sys = 1'b0;    // System clock, 100 MHz
	logic              rst_n = 1'b0;      // Reset, low for 10 cycles
	logic              large_port = 1'b1; // Variant strap
	logic              req, we, rd_load, wr_load;
	logic [15:0]       daddr;
	logic [8:0]        page_value, rpage, wpage;
	logic              acc_valid, acc_we, trap;
	pdw_pkg::pdw_tgt_e acc_tgt;
	logic [23:0]       eff_addr;
	int                error_cnt = 0;
	int                total_checks = 0;
	// Clock: flip every half period
	always #5 clk_sys = ~clk_sys;
	pdw_core_model u_core (.clk_sys(clk_sys), .read_page_load(rd_load), .write_page_load(wr_load),
		.page_value(page_value), .req(req), .we(we), .daddr(daddr));
	pdw_window u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .large_port(large_port), .read_page_load(rd_load),
		.write_page_load(wr_load), .page_value(page_value), .req(req), .we(we), .daddr(daddr),
		.acc_valid(acc_valid), .acc_we(acc_we), .acc_tgt(acc_tgt), .effective_address(eff_addr),
		.address_error_trap(trap), .read_page_select(rpage), .write_page_select(wpage));
	// One access, judged in the cycle after it is taken; the address is not judged when refused
	task automatic acc(input logic w, input logic [15:0] a, input logic [23:0] x, input pdw_pkg::pdw_tgt_e t);
		u_core.issue(w, a);
		`CHK(acc_valid, 1'b1)
		`CHK(acc_we, w)
		`CHK(acc_tgt, t)
		`CHK(trap, t == pdw_pkg::PDW_TGT_NONE)
		if (t != pdw_pkg::PDW_TGT_NONE)
			`CHK(eff_addr, x)
	endtask : acc
	// Pages come out of reset on page one, with no access answered
	task automatic t_reset();
		`CHK(rpage, 9'h001)
		`CHK(wpage, 9'h001)
		`CHK(acc_valid, 1'b0)
		`CHK(trap, 1'b0)
	endtask : t_reset
	// Separate read and write pages, base access, window top edge
	task automatic t_pages();
		u_core.load(9'h002, 9'h003);
		`CHK(rpage, 9'h002)
		`CHK(wpage, 9'h003)
		acc(1'b0, 16'h8004, 24'h010004, pdw_pkg::PDW_TGT_EXT);
		acc(1'b1, 16'h8004, 24'h018004, pdw_pkg::PDW_TGT_EXT);
		acc(1'b0, 16'h1234, 24'h001234, pdw_pkg::PDW_TGT_BASE);
		acc(1'b0, 16'hFFFF, 24'h017FFF, pdw_pkg::PDW_TGT_EXT);
	endtask : t_pages
	// Page zero traps in the window but not for base accesses
	task automatic t_page0();
		u_core.load(9'h000, 9'h000);
		acc(1'b0, 16'h8000, 24'h000000, pdw_pkg::PDW_TGT_NONE);
		acc(1'b1, 16'hFFFF, 24'h000000, pdw_pkg::PDW_TGT_NONE);
		acc(1'b0, 16'h0800, 24'h000800, pdw_pkg::PDW_TGT_BASE);
	endtask : t_page0
	// Program space is read-only
	task automatic t_prog();
		u_core.load(9'h100, 9'h100);
		acc(1'b0, 16'h8010, 24'h800010, pdw_pkg::PDW_TGT_PROG);
		acc(1'b1, 16'h8010, 24'h800010, pdw_pkg::PDW_TGT_NONE);
	endtask : t_prog
	// Small variant reaches 64K only; the strap passes two flops, so pages reload while it settles
	task automatic t_small();
		large_port = 1'b0;
		u_core.load(9'h001, 9'h002);
		acc(1'b0, 16'hFFFE, 24'h00FFFE, pdw_pkg::PDW_TGT_EXT);
		acc(1'b1, 16'h8000, 24'h010000, pdw_pkg::PDW_TGT_NONE);
		large_port = 1'b1;
		u_core.load(9'h001, 9'h002);
		acc(1'b1, 16'h8000, 24'h010000, pdw_pkg::PDW_TGT_EXT);
	endtask : t_small
	// Reset in mid-run puts both pages back on page one and silences the answer
	task automatic t_rerun();
		u_core.load(9'h004, 9'h005);
		`CHK(rpage, 9'h004)
		rst_n = 1'b0;
		@(negedge clk_sys);
		`CHK(rpage, 9'h001)
		`CHK(wpage, 9'h001)
		`CHK(acc_valid, 1'b0)
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		acc(1'b1, 16'h8004, 24'h008004, pdw_pkg::PDW_TGT_EXT);
	endtask : t_rerun
	// Verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// Main sequence
	initial
	begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_reset();
		t_pages();
		t_page0();
		t_prog();
		t_small();
		t_rerun();
		stop_test();
	end
	// Watchdog: the tests need well under 100 cycles
	initial
	begin
		#5000;
		error_cnt++;
		stop_test();
	end
endmodule : paged_data_window_bench
`default_nettype wire
